// File: hw/mecc_defs.svh
`ifndef MECC_DEFS_SVH
`define MECC_DEFS_SVH
// controller register byte offsets
`define MECC_OFS_CTRL 8'h00
`define MECC_OFS_CMD 8'h04
`define MECC_OFS_ADDR 8'h08
`define MECC_OFS_WLO 8'h0c
`define MECC_OFS_WHI 8'h10
`define MECC_OFS_RLO 8'h14
`define MECC_OFS_RHI 8'h18
`define MECC_OFS_STAT 8'h1c
// controller control bits
`define MECC_BIT_EVT_EXPORT 4
`define MECC_BIT_CHK_PROG 25
`define MECC_BIT_CHK_DATA0 26
`define MECC_BIT_CHK_DATA1 27
`define MECC_CTRL_RESET 32'h0000_0000
// controller command bits
`define MECC_CMD_RAM_WR 0
`define MECC_CMD_RAM_RD 1
`define MECC_CMD_FL_RD 2
// controller status bits
`define MECC_ST_DONE 0
`define MECC_ST_SBE 1
`define MECC_ST_MBE 2
`define MECC_ST_BUSY 3
// axi responses
`define MECC_RESP_OKAY 2'b00
`define MECC_RESP_SLVERR 2'b10
// device register indices
`define MECC_DR_STAT 3'h0
`define MECC_DR_SBE_ADDR 3'h1
`define MECC_DR_MBE_ADDR 3'h2
`define MECC_DR_PCTRL 3'h3
`define MECC_DR_PERR_ADDR 3'h4
`define MECC_DR_INIT 3'h5
// device status bits, write one to clear except MECC_DS_INIT, which reads the init run state
`define MECC_DS_SBE 0
`define MECC_DS_MBE 1
`define MECC_DS_PAR 2
`define MECC_DS_APAR 3
`define MECC_DS_DEC 4
`define MECC_DS_INIT 5
// peripheral parity control bits
`define MECC_PC_EN 0
`define MECC_PC_ODD 1
`define MECC_PC_IRQ 2
`endif

// File: hw/mecc_pkg.sv
package mecc_pkg;
  typedef logic [7:0] mecc_code_t;
  typedef enum logic [2:0] {
    MECC_IDLE = 3'b001,
    MECC_REQ = 3'b010,
    MECC_WAIT = 3'b100
  } mecc_state_t;
  typedef enum logic [1:0] {
    MECC_INI_IDLE = 2'b01,
    MECC_INI_RUN = 2'b10
  } mecc_init_t;

  // extended hamming: data bits sit at non power of two positions 1..71
  function automatic mecc_code_t mecc_ecc(input logic [63:0] d);
    mecc_code_t c;
    int k;
    c = 8'h00;
    k = 0;
    for (int pos = 1; pos < 72; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        c[6:0] = c[6:0] ^ ({7{d[k]}} & 7'(pos));
        k++;
      end
    end
    c[7] = (^d) ^ (^c[6:0]);
    return c;
  endfunction : mecc_ecc

  function automatic logic [63:0] mecc_fix(input logic [63:0] d, input logic [6:0] syn);
    logic [63:0] r;
    int k;
    r = d;
    k = 0;
    for (int pos = 1; pos < 72; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        if (7'(pos) == syn) r[k] = ~r[k];
        k++;
      end
    end
    return r;
  endfunction : mecc_fix
endpackage : mecc_pkg

// File: hw/mecc_tcm_if.sv
`timescale 1ns/1ps
interface mecc_tcm_if #(parameter int AW = 10, parameter int FAW = 10);
  // data coupled port (ram)
  logic ram_req;
  logic ram_we;
  logic [AW-1:0] ram_addr;
  logic ram_addr_par;
  logic [63:0] ram_wdata;
  logic [7:0] ram_wecc;
  logic ram_busy;
  logic ram_rvalid;
  logic [63:0] ram_rdata;
  logic [7:0] ram_recc;
  // program coupled port (flash)
  logic fl_req;
  logic [FAW-1:0] fl_addr;
  logic fl_rvalid;
  logic [63:0] fl_rdata;
  logic [7:0] fl_recc;
  // event bus
  logic evt_sbe;
  logic evt_mbe;
  logic [AW-1:0] evt_addr;
  modport dev (
    input ram_req, ram_we, ram_addr, ram_addr_par, ram_wdata, ram_wecc, fl_req, fl_addr,
    input evt_sbe, evt_mbe, evt_addr,
    output ram_busy, ram_rvalid, ram_rdata, ram_recc, fl_rvalid, fl_rdata, fl_recc
  );
  modport cpu (
    output ram_req, ram_we, ram_addr, ram_addr_par, ram_wdata, ram_wecc, fl_req, fl_addr,
    output evt_sbe, evt_mbe, evt_addr,
    input ram_busy, ram_rvalid, ram_rdata, ram_recc, fl_rvalid, fl_rdata, fl_recc
  );
endinterface : mecc_tcm_if

// File: hw/mecc_device.sv
// Local design decisions: the register addresses and the simple select and write port (reg_sel_in, reg_wr_in) to the registers.
`timescale 1ns/1ps
`include "mecc_defs.svh"
module mecc_device #(
  parameter int AW = 10,
  parameter int FAW = 10,
  parameter int PAW = 6
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // processor side
  mecc_tcm_if.dev tcm,
  // register port
  input wire logic [2:0] reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  // flash preload
  input wire logic fl_load_in,
  input wire logic [FAW-1:0] fl_load_addr_in,
  input wire logic [63:0] fl_load_data_in,
  // peripheral ram port
  input wire logic per_req_in,
  input wire logic per_we_in,
  input wire logic [PAW-1:0] per_addr_in,
  input wire logic [31:0] per_wdata_in,
  output logic per_rvalid_out,
  output logic [31:0] per_rdata_out,
  // error outputs
  output logic per_par_err_out,
  output logic per_irq_out,
  output logic sbe_irq_out,
  output logic mbe_irq_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [35:0] bank0_mem [2**AW];
  logic [35:0] bank1_mem [2**AW];
  logic [71:0] fl_mem [2**FAW];
  logic [31:0] per_mem [2**PAW];
  logic per_par_mem [2**PAW];
  mecc_pkg::mecc_init_t init_q;
  logic [AW-1:0] init_cnt_q;
  logic [5:0] stat_q;
  logic [AW-1:0] sbe_addr_q;
  logic [AW-1:0] mbe_addr_q;
  logic [PAW-1:0] perr_addr_q;
  logic [2:0] pctrl_q;
  logic ram_rvalid_q;
  logic [63:0] ram_rdata_q;
  logic [7:0] ram_recc_q;
  logic fl_rvalid_q;
  logic [63:0] fl_rdata_q;
  logic [7:0] fl_recc_q;
  logic per_rvalid_q;
  logic [31:0] per_rdata_q;
  logic per_err_q;
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  wire init_run = (init_q == mecc_pkg::MECC_INI_RUN);
  wire take = tcm.ram_req & ~init_run;
  wire apar_bad = take & ((^tcm.ram_addr) ^ tcm.ram_addr_par);
  wire acc_ok = take & ~apar_bad;
  // two decoders built differently; a stuck term in either shows as mismatch
  wire [1:0] dec_a = {2{acc_ok}} & {tcm.ram_addr[AW-1], ~tcm.ram_addr[AW-1]};
  wire [1:0] dec_b = acc_ok ? (2'b01 << tcm.ram_addr[AW-1]) : 2'b00;
  wire dec_bad = (dec_a != dec_b);
  wire cs0 = |dec_a;
  wire cs1 = |dec_b;
  wire ecc_sel = (dec_a == dec_b) & cs0;
  wire wr0 = cs0 & tcm.ram_we;
  wire wr1 = cs1 & tcm.ram_we;
  wire [63:0] wd = tcm.ram_wdata;
  // even bytes plus low code nibble in bank 0, odd bytes plus high nibble in bank 1
  wire [35:0] wb0 = {tcm.ram_wecc[3:0], wd[55:48], wd[39:32], wd[23:16], wd[7:0]};
  wire [35:0] wb1 = {tcm.ram_wecc[7:4], wd[63:56], wd[47:40], wd[31:24], wd[15:8]};
  wire [7:0] init_ecc = mecc_pkg::mecc_ecc(64'h0000_0000_0000_0000);
  wire [35:0] init_b0 = {init_ecc[3:0], 32'h0000_0000};
  wire [35:0] init_b1 = {init_ecc[7:4], 32'h0000_0000};
  wire [35:0] rb0 = bank0_mem[tcm.ram_addr];
  wire [35:0] rb1 = bank1_mem[tcm.ram_addr];
  wire [63:0] rd_word = {rb1[31:24], rb0[31:24], rb1[23:16], rb0[23:16],
                         rb1[15:8], rb0[15:8], rb1[7:0], rb0[7:0]};
  wire [7:0] rd_ecc = {rb1[35:32], rb0[35:32]};

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (init_run) begin
      bank0_mem[init_cnt_q] <= init_b0;
      bank1_mem[init_cnt_q] <= init_b1;
    end else begin
      if (wr0 & ecc_sel) bank0_mem[tcm.ram_addr] <= wb0;
      if (wr1 & ecc_sel) bank1_mem[tcm.ram_addr] <= wb1;
    end
    if (fl_load_in) fl_mem[fl_load_addr_in] <= {mecc_pkg::mecc_ecc(fl_load_data_in),
                                                fl_load_data_in};
    if (per_req_in & per_we_in) begin
      per_mem[per_addr_in] <= per_wdata_in;
      per_par_mem[per_addr_in] <= (^per_wdata_in) ^ pctrl_q[`MECC_PC_ODD];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire init_go = reg_wr_in & (reg_sel_in == `MECC_DR_INIT) & reg_wdata_in[0];
  wire init_last = (init_cnt_q == {AW{1'b1}});
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      init_q <= mecc_pkg::MECC_INI_IDLE;
      init_cnt_q <= '0;
    end else begin
      case (init_q)
        mecc_pkg::MECC_INI_IDLE: begin
          init_cnt_q <= '0;
          if (init_go) init_q <= mecc_pkg::MECC_INI_RUN;
        end
        mecc_pkg::MECC_INI_RUN: begin
          init_cnt_q <= init_cnt_q + 1'b1;
          if (init_last) init_q <= mecc_pkg::MECC_INI_IDLE;
        end
        default: init_q <= mecc_pkg::MECC_INI_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ram_rvalid_q <= 1'b0;
      ram_rdata_q <= '0;
      ram_recc_q <= '0;
      fl_rvalid_q <= 1'b0;
      fl_rdata_q <= '0;
      fl_recc_q <= '0;
    end else begin
      ram_rvalid_q <= take & ~tcm.ram_we;
      if (take & ~tcm.ram_we) begin
        ram_rdata_q <= rd_word;
        ram_recc_q <= rd_ecc;
      end
      fl_rvalid_q <= tcm.fl_req;
      if (tcm.fl_req) begin
        fl_rdata_q <= fl_mem[tcm.fl_addr][63:0];
        fl_recc_q <= fl_mem[tcm.fl_addr][71:64];
      end
    end
  end
  assign tcm.ram_busy = init_run;
  assign tcm.ram_rvalid = ram_rvalid_q;
  assign tcm.ram_rdata = ram_rdata_q;
  assign tcm.ram_recc = ram_recc_q;
  assign tcm.fl_rvalid = fl_rvalid_q;
  assign tcm.fl_rdata = fl_rdata_q;
  assign tcm.fl_recc = fl_recc_q;

  ////////////////////////////////////////////////////////////////////////////
  // peripheral ram read; the data goes back whatever the parity says
  wire per_rd = per_req_in & ~per_we_in;
  wire [31:0] per_word = per_mem[per_addr_in];
  wire per_calc = (^per_word) ^ pctrl_q[`MECC_PC_ODD];
  wire per_bad = per_rd & pctrl_q[`MECC_PC_EN] & (per_calc != per_par_mem[per_addr_in]);
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      per_rvalid_q <= 1'b0;
      per_rdata_q <= '0;
      per_err_q <= 1'b0;
    end else begin
      per_rvalid_q <= per_rd;
      if (per_rd) per_rdata_q <= per_word;
      per_err_q <= per_bad;
    end
  end
  assign per_rvalid_out = per_rvalid_q;
  assign per_rdata_out = per_rdata_q;
  assign per_par_err_out = per_err_q;

  ////////////////////////////////////////////////////////////////////////////
  wire stat_wr = reg_wr_in & (reg_sel_in == `MECC_DR_STAT);
  wire [5:0] clr = stat_wr ? reg_wdata_in[5:0] : 6'h00;
  wire ev_s = tcm.evt_sbe;
  wire ev_m = tcm.evt_mbe;
  wire [5:0] set = {1'b0, dec_bad, apar_bad, per_bad, ev_m, ev_s};
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stat_q <= '0;
      sbe_addr_q <= '0;
      mbe_addr_q <= '0;
      perr_addr_q <= '0;
      pctrl_q <= 3'h0;
    end else begin
      stat_q <= set | (stat_q & ~clr);
      // capture only into an empty slot so the first failure is kept
      if (ev_s & ~stat_q[`MECC_DS_SBE]) sbe_addr_q <= tcm.evt_addr;
      if (ev_m & ~stat_q[`MECC_DS_MBE]) mbe_addr_q <= tcm.evt_addr;
      if (per_bad & ~stat_q[`MECC_DS_PAR]) perr_addr_q <= per_addr_in;
      if (reg_wr_in & (reg_sel_in == `MECC_DR_PCTRL)) pctrl_q <= reg_wdata_in[2:0];
    end
  end
  assign sbe_irq_out = stat_q[`MECC_DS_SBE];
  assign mbe_irq_out = stat_q[`MECC_DS_MBE];
  assign per_irq_out = stat_q[`MECC_DS_PAR] & pctrl_q[`MECC_PC_IRQ];

  ////////////////////////////////////////////////////////////////////////////
  wire [5:0] stat_view = {init_run, stat_q[4:0]};
  wire [31:0] rmux =
    (reg_sel_in == `MECC_DR_STAT) ? {26'h0, stat_view} :
    (reg_sel_in == `MECC_DR_SBE_ADDR) ? 32'(sbe_addr_q) :
    (reg_sel_in == `MECC_DR_MBE_ADDR) ? 32'(mbe_addr_q) :
    (reg_sel_in == `MECC_DR_PCTRL) ? {29'h0, pctrl_q} :
    (reg_sel_in == `MECC_DR_PERR_ADDR) ? 32'(perr_addr_q) :
    (reg_sel_in == `MECC_DR_INIT) ? {31'h0, init_run} : 32'h0000_0000;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) rdata_q <= '0;
    else rdata_q <= rmux;
  end
  assign reg_rdata_out = rdata_q;
endmodule : mecc_device

// File: hw/mecc_cpu.sv
`timescale 1ns/1ps
`include "mecc_defs.svh"
module mecc_cpu #(
  parameter int AW = 10,
  parameter int FAW = 10
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // axi4-lite slave
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // memory side
  mecc_tcm_if.cpu tcm
);
  ////////////////////////////////////////////////////////////////////////////
  logic aw_v_q, w_v_q, b_v_q, r_v_q;
  logic [7:0] aw_q;
  logic [31:0] w_q, rd_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] ctrl_q, addr_q, wlo_q, whi_q;
  logic [63:0] res_q;
  logic [2:0] cmd_q;
  logic done_q, sbe_q, mbe_q, esbe_q, embe_q;
  mecc_pkg::mecc_state_t st_q;

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready_out = ~aw_v_q & ~b_v_q;
  assign s_axi_wready_out = ~w_v_q & ~b_v_q;
  assign s_axi_arready_out = ~r_v_q;
  wire wr_go = aw_v_q & w_v_q & ~b_v_q;
  wire idle = (st_q == mecc_pkg::MECC_IDLE);
  wire wsel_ctrl = wr_go & (aw_q == `MECC_OFS_CTRL);
  wire wsel_cmd = wr_go & (aw_q == `MECC_OFS_CMD);
  wire wsel_addr = wr_go & (aw_q == `MECC_OFS_ADDR);
  wire wsel_wlo = wr_go & (aw_q == `MECC_OFS_WLO);
  wire wsel_whi = wr_go & (aw_q == `MECC_OFS_WHI);
  wire w_known = wsel_ctrl | wsel_cmd | wsel_addr | wsel_wlo | wsel_whi;
  wire start = wsel_cmd & idle & (|w_q[2:0]);
  wire [31:0] stat_w = {28'h0, ~idle, mbe_q, sbe_q, done_q};
  wire [7:0] ra = s_axi_araddr_in;
  wire r_known = (ra[7:5] == 3'b000) & (ra[1:0] == 2'b00);
  wire [31:0] rmux =
    (ra == `MECC_OFS_CTRL) ? ctrl_q :
    (ra == `MECC_OFS_CMD) ? {29'h0, cmd_q} :
    (ra == `MECC_OFS_ADDR) ? addr_q :
    (ra == `MECC_OFS_WLO) ? wlo_q :
    (ra == `MECC_OFS_WHI) ? whi_q :
    (ra == `MECC_OFS_RLO) ? res_q[31:0] :
    (ra == `MECC_OFS_RHI) ? res_q[63:32] :
    (ra == `MECC_OFS_STAT) ? stat_w : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_v_q <= 1'b0;
      w_v_q <= 1'b0;
      b_v_q <= 1'b0;
      r_v_q <= 1'b0;
      aw_q <= '0;
      w_q <= '0;
      rd_q <= '0;
      bresp_q <= `MECC_RESP_OKAY;
      rresp_q <= `MECC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in & s_axi_awready_out) begin
        aw_v_q <= 1'b1;
        aw_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in & s_axi_wready_out) begin
        w_v_q <= 1'b1;
        w_q <= s_axi_wdata_in;
      end
      if (wr_go) begin
        aw_v_q <= 1'b0;
        w_v_q <= 1'b0;
        b_v_q <= 1'b1;
        bresp_q <= w_known ? `MECC_RESP_OKAY : `MECC_RESP_SLVERR;
      end else if (s_axi_bready_in) b_v_q <= 1'b0;
      if (s_axi_arvalid_in & s_axi_arready_out) begin
        r_v_q <= 1'b1;
        rd_q <= rmux;
        rresp_q <= r_known ? `MECC_RESP_OKAY : `MECC_RESP_SLVERR;
      end else if (s_axi_rready_in) r_v_q <= 1'b0;
    end
  end
  assign s_axi_bvalid_out = b_v_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_rvalid_out = r_v_q;
  assign s_axi_rdata_out = rd_q;
  assign s_axi_rresp_out = rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  wire is_fl = cmd_q[`MECC_CMD_FL_RD];
  wire [63:0] got_d = is_fl ? tcm.fl_rdata : tcm.ram_rdata;
  wire [7:0] got_c = is_fl ? tcm.fl_recc : tcm.ram_recc;
  wire [7:0] calc = mecc_pkg::mecc_ecc(got_d);
  wire [6:0] syn = got_c[6:0] ^ calc[6:0];
  wire ovr = (^got_d) ^ (^got_c);
  wire chk_en = is_fl ? ctrl_q[`MECC_BIT_CHK_PROG] :
                addr_q[0] ? ctrl_q[`MECC_BIT_CHK_DATA1] : ctrl_q[`MECC_BIT_CHK_DATA0];
  wire e_single = chk_en & ovr;
  wire e_multi = chk_en & ~ovr & (syn != 7'h00);
  wire got = is_fl ? tcm.fl_rvalid : tcm.ram_rvalid;
  wire taken = is_fl | ~tcm.ram_busy;
  wire exp_on = ctrl_q[`MECC_BIT_EVT_EXPORT];

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= mecc_pkg::MECC_IDLE;
      ctrl_q <= `MECC_CTRL_RESET;
      addr_q <= '0;
      wlo_q <= '0;
      whi_q <= '0;
      res_q <= '0;
      cmd_q <= '0;
      done_q <= 1'b0;
      sbe_q <= 1'b0;
      mbe_q <= 1'b0;
      esbe_q <= 1'b0;
      embe_q <= 1'b0;
    end else begin
      esbe_q <= 1'b0;
      embe_q <= 1'b0;
      if (wsel_ctrl) ctrl_q <= w_q;
      if (wsel_addr & idle) addr_q <= w_q;
      if (wsel_wlo & idle) wlo_q <= w_q;
      if (wsel_whi & idle) whi_q <= w_q;
      case (st_q)
        mecc_pkg::MECC_IDLE: begin
          if (start) begin
            cmd_q <= w_q[2:0];
            done_q <= 1'b0;
            sbe_q <= 1'b0;
            mbe_q <= 1'b0;
            st_q <= mecc_pkg::MECC_REQ;
          end
        end
        mecc_pkg::MECC_REQ: begin
          if (taken) begin
            if (cmd_q[`MECC_CMD_RAM_WR]) begin
              done_q <= 1'b1;
              st_q <= mecc_pkg::MECC_IDLE;
            end else st_q <= mecc_pkg::MECC_WAIT;
          end
        end
        mecc_pkg::MECC_WAIT: begin
          if (got) begin
            res_q <= e_single ? mecc_pkg::mecc_fix(got_d, syn) : got_d;
            sbe_q <= e_single;
            mbe_q <= e_multi;
            esbe_q <= e_single & exp_on & ~is_fl;
            embe_q <= e_multi & exp_on & ~is_fl;
            done_q <= 1'b1;
            st_q <= mecc_pkg::MECC_IDLE;
          end
        end
        default: st_q <= mecc_pkg::MECC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire in_req = (st_q == mecc_pkg::MECC_REQ);
  wire [63:0] wword = {whi_q, wlo_q};
  assign tcm.ram_req = in_req & ~is_fl;
  assign tcm.ram_we = cmd_q[`MECC_CMD_RAM_WR];
  assign tcm.ram_addr = addr_q[AW-1:0];
  assign tcm.ram_addr_par = ^addr_q[AW-1:0];
  assign tcm.ram_wdata = wword;
  assign tcm.ram_wecc = mecc_pkg::mecc_ecc(wword);
  assign tcm.fl_req = in_req & is_fl;
  assign tcm.fl_addr = addr_q[FAW-1:0];
  assign tcm.evt_sbe = esbe_q;
  assign tcm.evt_mbe = embe_q;
  assign tcm.evt_addr = addr_q[AW-1:0];
endmodule : mecc_cpu

// File: dv/mecc_assertions.sv
`timescale 1ns/1ps
module mecc_assertions #(parameter int AW = 10) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // coupled port signals
  input wire logic ram_req,
  input wire logic ram_we,
  input wire logic ram_busy,
  input wire logic ram_rvalid,
  input wire logic ram_addr_par,
  input wire logic [AW-1:0] ram_addr,
  input wire logic [63:0] ram_wdata,
  input wire logic [63:0] ram_rdata,
  input wire logic [7:0] ram_wecc,
  input wire logic [7:0] ram_recc,
  input wire logic fl_req,
  input wire logic fl_rvalid
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire logic rd_take = ram_req && !ram_we && !ram_busy;
  wire logic wr_take = ram_req && ram_we && !ram_busy;
  logic wv_q;
  logic [AW-1:0] wa_q;
  logic [71:0] wd_q;
  ////////////////////////////////////////
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) wv_q <= 1'b0;
    else if (ram_busy) wv_q <= 1'b0;
    else if (wr_take) wv_q <= 1'b1;
  end
  always_ff @(posedge clk_in) begin
    if (wr_take) wa_q <= ram_addr;
    if (wr_take) wd_q <= {ram_wdata, ram_wecc};
  end
  wire logic hit = rd_take && wv_q && (ram_addr == wa_q);
  ////////////////////////////////////////
  property p_rd_answer; rd_take |=> ram_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("ram read unanswered");
  property p_rv_cause; ram_rvalid |-> $past(rd_take); endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("ram answer uncaused");
  property p_fl_answer; fl_req |=> fl_rvalid; endproperty
  a_fl_answer: assert property (p_fl_answer) else $error("flash read unanswered");
  property p_addr_par; ram_req |-> ram_addr_par == ^ram_addr; endproperty
  a_addr_par: assert property (p_addr_par) else $error("address parity wrong");
  property p_rd_hold; !ram_rvalid |-> $stable(ram_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_code_kept; hit |=> ram_recc == wd_q[7:0]; endproperty
  a_code_kept: assert property (p_code_kept) else $error("stored code altered");
  property p_data_kept; hit |=> ram_rdata == wd_q[71:8]; endproperty
  a_data_kept: assert property (p_data_kept) else $error("stored word altered");
  property p_busy_refuse; ram_busy |=> !ram_rvalid; endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("read taken in init");
endmodule : mecc_assertions

// File: dv/memory_ecc_parity_guard_tb.sv
`timescale 1ns/1ps
`include "mecc_defs.svh"
module memory_ecc_parity_guard_tb;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0, reg_wdata_in = 32'h0, per_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, per_rvalid_out, per_par_err_out, per_irq_out;
  logic sbe_irq_out, mbe_irq_out, e, seen_busy = 1'b0;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp;
  logic [31:0] s_axi_rdata_out, reg_rdata_out, per_rdata_out, v, lo, hi;
  logic [2:0] reg_sel_in = 3'h0;
  logic reg_wr_in = 1'b0, fl_load_in = 1'b0, per_req_in = 1'b0, per_we_in = 1'b0;
  logic [9:0] fl_load_addr_in = 10'h000;
  logic [63:0] fl_load_data_in = 64'h0, w;
  logic [5:0] per_addr_in = 6'h00;
  logic [15:0] lfsr = 16'h4915;
  logic [63:0] ram_m [int];
  int mismatches = 0, check_count = 0, cycles = 0;
  mecc_tcm_if #(.AW(10), .FAW(10)) tcm_bus ();
  mecc_cpu #(.AW(10), .FAW(10)) u_mecc_cpu (
    .clk_in, .resetn_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_araddr_in, .s_axi_rvalid_out, .s_axi_rready_in,
    .s_axi_rdata_out, .s_axi_rresp_out, .tcm(tcm_bus));
  mecc_device #(.AW(10), .FAW(10), .PAW(6)) u_mecc_device (
    .clk_in, .resetn_in, .tcm(tcm_bus), .reg_sel_in, .reg_wr_in, .reg_wdata_in,
    .reg_rdata_out, .fl_load_in, .fl_load_addr_in, .fl_load_data_in, .per_req_in,
    .per_we_in, .per_addr_in, .per_wdata_in, .per_rvalid_out, .per_rdata_out,
    .per_par_err_out, .per_irq_out, .sbe_irq_out, .mbe_irq_out);
  mecc_assertions #(.AW(10)) u_mecc_assertions (
    .clk_in, .resetn_in, .ram_req(tcm_bus.ram_req), .ram_we(tcm_bus.ram_we),
    .ram_busy(tcm_bus.ram_busy), .ram_rvalid(tcm_bus.ram_rvalid),
    .ram_addr_par(tcm_bus.ram_addr_par), .ram_addr(tcm_bus.ram_addr),
    .ram_wdata(tcm_bus.ram_wdata), .ram_rdata(tcm_bus.ram_rdata),
    .ram_wecc(tcm_bus.ram_wecc), .ram_recc(tcm_bus.ram_recc),
    .fl_req(tcm_bus.fl_req), .fl_rvalid(tcm_bus.fl_rvalid));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (tcm_bus.ram_busy === 1'b1) seen_busy = 1'b1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic rnd(output logic [31:0] r);
    for (int i = 0; i < 32; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      r[i] = lfsr[0];
    end
  endtask : rnd
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'b111;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= lfsr[3:0];
    do begin
      @(posedge clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out);
    resp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    {s_axi_arvalid_in, s_axi_rready_in} <= 2'b11;
    s_axi_araddr_in <= a;
    do begin
      @(posedge clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out);
    {d, resp} = {s_axi_rdata_out, s_axi_rresp_out};
    s_axi_rready_in <= 1'b0;
  endtask : axi_rd
  task automatic run_cmd(input int op, input logic [9:0] a, output logic [63:0] q);
    logic [31:0] st, l, h;
    axi_wr(`MECC_OFS_ADDR, {22'h0, a});
    axi_wr(`MECC_OFS_CMD, 32'h1 << op);
    st = 32'h8;
    for (int i = 0; i < 20 && st[`MECC_ST_BUSY]; i++) axi_rd(`MECC_OFS_STAT, st);
    chk("cmd_stat", st[2:0], 3'b001);
    axi_rd(`MECC_OFS_RLO, l);
    axi_rd(`MECC_OFS_RHI, h);
    q = {h, l};
  endtask : run_cmd
  task automatic dev_wr(input logic [2:0] s, input logic [31:0] d);
    @(posedge clk_in);
    reg_sel_in <= s;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : dev_wr
  task automatic dev_rd(input logic [2:0] s, output logic [31:0] q);
    @(posedge clk_in);
    reg_sel_in <= s;
    @(posedge clk_in);
    @(negedge clk_in);
    q = reg_rdata_out;
  endtask : dev_rd
  task automatic per_acc(input logic we, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_in);
    per_req_in <= 1'b1;
    per_we_in <= we;
    per_addr_in <= a;
    per_wdata_in <= d;
    @(posedge clk_in);
    per_req_in <= 1'b0;
    @(negedge clk_in);
    v = per_rdata_out;
    e = per_par_err_out;
    if (!we) chk("per_rvalid", per_rvalid_out, 1'b1);
  endtask : per_acc
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    axi_rd(`MECC_OFS_CTRL, v);
    chk("ctrl_reset", v, `MECC_CTRL_RESET);
    axi_rd(8'h20, v);
    chk("unmapped_rresp", resp, `MECC_RESP_SLVERR);
    chk("unmapped_rdata", v, 32'h0);
    axi_wr(8'h24, 32'h1);
    chk("unmapped_bresp", resp, `MECC_RESP_SLVERR);
    dev_rd(`MECC_DR_PCTRL, v);
    chk("pctrl_reset", v, 32'h0);
    $display("test reset done");
    dev_wr(`MECC_DR_INIT, 32'h1);
    v = 32'h20;
    for (int i = 0; i < 1200 && v[`MECC_DS_INIT]; i++) dev_rd(`MECC_DR_STAT, v);
    chk("init_busy_seen", seen_busy, 1'b1);
    chk("init_done", v[`MECC_DS_INIT], 1'b0);
    axi_wr(`MECC_OFS_CTRL, 32'h0e00_0010);
    axi_rd(`MECC_OFS_CTRL, v);
    chk("ctrl_enables", v, 32'h0e00_0010);
    run_cmd(`MECC_CMD_RAM_RD, 10'h3ff, w);
    chk("init_word", w, 64'h0);
    $display("test init done");
    for (int i = 0; i < 6; i++) begin
      rnd(lo);
      rnd(hi);
      ram_m[i * 37] = {hi, lo};
      axi_wr(`MECC_OFS_WLO, lo);
      axi_wr(`MECC_OFS_WHI, hi);
      run_cmd(`MECC_CMD_RAM_WR, 10'(i * 37), w);
    end
    foreach (ram_m[a]) begin
      run_cmd(`MECC_CMD_RAM_RD, 10'(a), w);
      chk("ram_word", w, ram_m[a]);
    end
    $display("test ram done");
    for (int i = 1; i < 4; i++) begin
      rnd(lo);
      rnd(hi);
      @(posedge clk_in);
      fl_load_in <= 1'b1;
      fl_load_addr_in <= 10'(i * 100);
      fl_load_data_in <= {hi, lo};
      @(posedge clk_in);
      fl_load_in <= 1'b0;
      run_cmd(`MECC_CMD_FL_RD, 10'(i * 100), w);
      chk("fl_word", w, {hi, lo});
    end
    $display("test flash done");
    rnd(lo);
    per_acc(1'b1, 6'h05, lo);
    dev_wr(`MECC_DR_PCTRL, 32'h2);
    per_acc(1'b0, 6'h05, 32'h0);
    chk("per_off_err", e, 1'b0);
    dev_wr(`MECC_DR_PCTRL, 32'h5);
    per_acc(1'b1, 6'h05, lo);
    per_acc(1'b0, 6'h05, 32'h0);
    chk("per_even_err", e, 1'b0);
    dev_wr(`MECC_DR_PCTRL, 32'h7);
    per_acc(1'b0, 6'h05, 32'h0);
    chk("per_odd_err", e, 1'b1);
    chk("per_err_data", v, lo);
    dev_rd(`MECC_DR_PERR_ADDR, v);
    chk("per_err_addr", v, 32'h5);
    chk("per_irq_on", per_irq_out, 1'b1);
    dev_wr(`MECC_DR_STAT, 32'h1 << `MECC_DS_PAR);
    dev_rd(`MECC_DR_STAT, v);
    chk("per_flag_clear", v[4:0], 5'h00);
    chk("per_irq_off", per_irq_out, 1'b0);
    chk("ecc_irqs", {sbe_irq_out, mbe_irq_out}, 2'b00);
    $display("test peripheral done");
    end_of_test();
  end
endmodule : memory_ecc_parity_guard_tb
